// >>> rtl/wofd_defs.vh
// Constants for the wake-on-LAN frame detector
`ifndef WOFD_DEFS_VH
`define WOFD_DEFS_VH

// Filter configuration word fields
`define WOFD_CFG_EN_BIT      31
`define WOFD_CFG_TYPE_HI     25
`define WOFD_CFG_TYPE_LO     24
`define WOFD_CFG_OFS_HI      23
`define WOFD_CFG_OFS_LO      16
`define WOFD_CFG_CRC_HI      15
`define WOFD_CFG_CRC_LO      0

// Word selects on the filter write port
`define WOFD_SEL_CFG         3'h0
`define WOFD_SEL_MASK0       3'h1
`define WOFD_SEL_MASK1       3'h2
`define WOFD_SEL_MASK2       3'h3
`define WOFD_SEL_MASK3       3'h4

// Reset values
`define WOFD_CFG_RST         32'h0000_0000
`define WOFD_MASK_RST        128'h0
`define WOFD_CRC_INIT        16'hffff

// Address types
`define WOFD_TYPE_UNICAST    2'h0
`define WOFD_TYPE_MULTICAST  2'h2

// Magic packet shape
`define WOFD_SYNC_LEN        3'h6
`define WOFD_ADDR_BYTES      3'h6
`define WOFD_MAGIC_REPS      4'hf
`define WOFD_SYNC_BYTE       8'hff

// Mask window length in bytes
`define WOFD_MASK_LEN        8'h80

`endif

// >>> rtl/wofd_detector.v
// Receive-side wake-on-LAN detector: perfect DA, wake-frame filters, magic packet
//
// Functional notes
// R1: Perfect-DA enable plus suspend enters DA detection
// R2: Station address match sets status and wakes
// R3: One frame may set several statuses together
// R4: Normal reception off while any enable set
// R5: Software clears statuses before each suspend
// R6: Masked bytes feed CRC-16, compared with stored
// R7: Wake-frame enable detects patterns, then wakes
// R8: Thirty-two filters, enable and address type
// R9: Wake frame needs address check and CRC
// R10: Offset plus mask bit j selects byte
// R11: Final CRC equals expected value means wake
// R12: Offset and CRC in config, mask four words
// R13: Software programs filters before enabling detection
// R14: CRC preset all ones, advanced on selected bytes
// R15: Intermediate terms chain crc bits and data
// R16: Next CRC built from terms and old bits
// R17: Address type selects unicast, multicast or any
// R18: Magic enable detects magic packet, then wakes
// R19: Magic scan on station or multicast frames
// R20: Sync run then sixteen address copies anywhere
// R21: Multicast frame accepted with sixteen copies
// R22: Resume clears statuses when option set
// R23: Statuses sticky until cleared, events OR in
`timescale 1ns/1ns
`include "wofd_defs.vh"

module wofd_detector #(
  parameter NUM_FILTERS = 32,  // Independent wake-frame filters
  parameter POS_W       = 16   // Byte position counter width
) (
  input  wire        mclk_in,                     // Receive clock
  input  wire        resetn_in,                   // Synchronous reset, active low
  input  wire        rx_valid_in,                 // Byte strobe from MAC receive path
  input  wire [7:0]  rx_data_in,                  // Received byte
  input  wire        rx_sof_in,                   // First byte of frame
  input  wire        rx_eof_in,                   // Last byte of frame
  input  wire        rx_frame_ok_in,              // Frame good, with eof
  input  wire        rx_filter_pass_in,           // Regular receive filter passed, with eof
  input  wire        perfect_da_wake_enable_in,   // Perfect-DA wake enable
  input  wire        wake_frame_enable_in,        // Wake-frame enable
  input  wire        magic_packet_enable_in,      // Magic-packet enable
  input  wire        other_wake_enables_in,       // Any other wake enable of either register
  input  wire        suspend_state_zero_in,       // Device in suspend state zero
  input  wire        suspend_state_one_in,        // Device in suspend state one
  input  wire        suspend_state_three_in,      // Device in suspend state three
  input  wire [15:0] station_addr_high_in,        // Station address bytes 4..5
  input  wire [31:0] station_addr_low_in,         // Station address bytes 0..3
  input  wire        filt_wr_in,                  // Filter word write strobe
  input  wire [4:0]  filt_index_in,               // Filter number
  input  wire [2:0]  filt_sel_in,                 // Config or mask word select
  input  wire [31:0] filt_wdata_in,               // Write data
  input  wire [2:0]  status_clear_in,             // Clear pulses: {magic, frame, da}
  input  wire        resume_in,                   // Resume signaling pulse
  input  wire        resume_clears_wake_status_in,// Resume clears statuses
  output reg         perfect_da_received_out,     // Sticky status
  output reg         wake_frame_received_out,     // Sticky status
  output reg         magic_packet_received_out,   // Sticky status
  output reg         remote_wakeup_out,           // One-cycle wake request
  output reg         normal_rx_enable_out         // Normal reception allowed
);

  // Filter storage
  reg  [31:0]  cfg_mem  [0:NUM_FILTERS-1];   // Per-filter configuration words
  reg  [127:0] mask_mem [0:NUM_FILTERS-1];   // Per-filter byte masks
  integer      k;                            // Reset loop index

  // Frame tracking
  reg  [POS_W-1:0] pos_q;                    // Position of next byte
  reg              da_eq_q;                  // DA matches station so far
  reg              da_mc_q;                  // DA is multicast (includes broadcast)
  reg  [2:0]       ff_cnt_q;                 // Consecutive sync bytes seen
  reg  [2:0]       col_q;                    // Address byte index within a copy
  reg  [3:0]       rep_q;                    // Completed address copies
  reg              magic_hit_q;              // Magic sequence seen in this frame

  wire             suspended;                // Watching for wake events
  wire [POS_W-1:0] cur_pos;                  // Position of current byte
  wire [47:0]      station;                  // Station address, byte 0 lowest
  wire [NUM_FILTERS-1:0] fhit;               // Per-filter wake result at eof
  wire             byte_in;                  // Byte taken this cycle
  wire             frame_end;                // Good frame ends this cycle

  assign suspended = suspend_state_zero_in | suspend_state_one_in |
                     suspend_state_three_in;
  assign cur_pos   = rx_sof_in ? {POS_W{1'b0}} : pos_q;
  assign station   = {station_addr_high_in, station_addr_low_in};
  assign byte_in   = rx_valid_in;
  assign frame_end = rx_valid_in & rx_eof_in & rx_frame_ok_in;

  // Station address byte lookup
  function [7:0] addr_byte;
    input [47:0] a;
    input [2:0]  idx;
    begin
      case (idx)
        3'h0:    addr_byte = a[7:0];
        3'h1:    addr_byte = a[15:8];
        3'h2:    addr_byte = a[23:16];
        3'h3:    addr_byte = a[31:24];
        3'h4:    addr_byte = a[39:32];
        default: addr_byte = a[47:40];
      endcase
    end
  endfunction

  // One CRC-16 step over a byte
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  d;
    reg   [7:0]  f;
    integer      i;
    begin
      f[0] = c[15] ^ d[0];  // [R15]
      for (i = 1; i < 8; i = i + 1) begin
        f[i] = c[15-i] ^ f[i-1] ^ d[i];  // [R15]
      end
      crc_step[15]    = c[7] ^ f[7];  // [R16]
      crc_step[14:10] = c[6:2];  // [R16]
      crc_step[9]     = c[1] ^ f[0];  // [R16]
      crc_step[8]     = c[0] ^ f[1];  // [R16]
      // Bit k of 7..2 takes terms (7-k) and (9-k)
      crc_step[7:2]   = {f[0] ^ f[2], f[1] ^ f[3], f[2] ^ f[4],
                         f[3] ^ f[5], f[4] ^ f[6], f[5] ^ f[7]};  // [R16]
      crc_step[1]     = f[6];  // [R16]
      crc_step[0]     = f[7];  // [R16]
    end
  endfunction

  // Host writes of filter configuration and mask words
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      for (k = 0; k < NUM_FILTERS; k = k + 1) begin
        cfg_mem[k]  <= `WOFD_CFG_RST;
        mask_mem[k] <= `WOFD_MASK_RST;
      end
    end else if (filt_wr_in) begin
      case (filt_sel_in)
        `WOFD_SEL_CFG:   cfg_mem[filt_index_in] <= filt_wdata_in;  // [R12]
        `WOFD_SEL_MASK0: mask_mem[filt_index_in][31:0]   <= filt_wdata_in;  // [R12]
        `WOFD_SEL_MASK1: mask_mem[filt_index_in][63:32]  <= filt_wdata_in;  // [R12]
        `WOFD_SEL_MASK2: mask_mem[filt_index_in][95:64]  <= filt_wdata_in;  // [R12]
        `WOFD_SEL_MASK3: mask_mem[filt_index_in][127:96] <= filt_wdata_in;  // [R12]
        default: ;  // Unused selects ignored
      endcase
    end
  end

  // Per-filter CRC engines
  genvar g;
  generate
    for (g = 0; g < NUM_FILTERS; g = g + 1) begin : filt
      reg  [15:0]      crc_q;     // Running CRC
      wire [31:0]      cfg;       // Configuration word
      wire [127:0]     mask;      // Byte mask
      wire [POS_W-1:0] rel;       // Position relative to pattern offset
      wire             in_win;    // Byte inside 128-byte window
      wire             sel;       // Byte enters CRC
      wire [15:0]      base;      // CRC before this byte
      wire [15:0]      crc_now;   // CRC including this byte
      wire [1:0]       atype;     // Destination address type
      wire             type_ok;   // Address type allows this frame

      assign cfg     = cfg_mem[g];
      assign mask    = mask_mem[g];
      assign rel     = cur_pos - {{(POS_W-8){1'b0}},
                                  cfg[`WOFD_CFG_OFS_HI:`WOFD_CFG_OFS_LO]};
      assign in_win  = (cur_pos >= {{(POS_W-8){1'b0}},
                                    cfg[`WOFD_CFG_OFS_HI:`WOFD_CFG_OFS_LO]}) &&
                       (rel < {{(POS_W-8){1'b0}}, `WOFD_MASK_LEN});  // [R10]
      assign sel     = in_win & mask[rel[6:0]];  // [R10] [R6]
      assign base    = rx_sof_in ? `WOFD_CRC_INIT : crc_q;  // [R14]
      assign crc_now = sel ? crc_step(base, rx_data_in) : base;  // [R14]
      assign atype   = cfg[`WOFD_CFG_TYPE_HI:`WOFD_CFG_TYPE_LO];
      assign type_ok = atype[0] ? 1'b1 :  // [R17]
                       (atype == `WOFD_TYPE_MULTICAST) ? da_mc_q :  // [R17]
                       (atype == `WOFD_TYPE_UNICAST) ? (~da_mc_q & da_eq_q) :  // [R17]
                       1'b0;
      // Enabled, CRC equal, passes receive filter and address type
      assign fhit[g] = cfg[`WOFD_CFG_EN_BIT] &  // [R8]
                       (crc_now == cfg[`WOFD_CFG_CRC_HI:`WOFD_CFG_CRC_LO]) &  // [R11]
                       rx_filter_pass_in & type_ok;  // [R9] [R17]

      // CRC accumulation
      always @(posedge mclk_in) begin
        if (!resetn_in) begin
          crc_q <= `WOFD_CRC_INIT;  // [R14]
        end else if (byte_in) begin
          crc_q <= crc_now;
        end
      end
    end
  endgenerate

  // Destination address and position tracking
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      pos_q   <= {POS_W{1'b0}};
      da_eq_q <= 1'b0;
      da_mc_q <= 1'b0;
    end else if (byte_in) begin
      // Saturate rather than wrap on long frames
      if (~&cur_pos) begin
        pos_q <= cur_pos + {{(POS_W-1){1'b0}}, 1'b1};
      end else begin
        pos_q <= cur_pos;
      end
      if (rx_sof_in) begin
        da_eq_q <= (rx_data_in == addr_byte(station, 3'h0));  // [R2]
        da_mc_q <= rx_data_in[0];  // Group bit, broadcast included
      end else if (cur_pos < {{(POS_W-3){1'b0}}, `WOFD_ADDR_BYTES}) begin
        da_eq_q <= da_eq_q & (rx_data_in == addr_byte(station, cur_pos[2:0]));  // [R2]
      end
    end
  end

  // Magic packet scanner, sequence may start anywhere in the frame
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      ff_cnt_q    <= 3'h0;
      col_q       <= 3'h0;
      rep_q       <= 4'h0;
      magic_hit_q <= 1'b0;
    end else if (byte_in) begin
      if (rx_sof_in) begin
        magic_hit_q <= 1'b0;
        ff_cnt_q    <= 3'h0;
        col_q       <= 3'h0;
        rep_q       <= 4'h0;
      end else if ((ff_cnt_q == `WOFD_SYNC_LEN) &&
                   (rx_data_in == addr_byte(station, col_q))) begin
        // Next address byte of the copies
        if (col_q == `WOFD_ADDR_BYTES - 3'h1) begin
          col_q <= 3'h0;
          if (rep_q == `WOFD_MAGIC_REPS) begin
            magic_hit_q <= 1'b1;  // [R20]
            rep_q       <= 4'h0;
            ff_cnt_q    <= 3'h0;
          end else begin
            rep_q <= rep_q + 4'h1;  // [R20]
          end
        end else begin
          col_q <= col_q + 3'h1;
        end
      end else begin
        // Mismatch: restart, a sync byte may continue or begin a run
        col_q <= 3'h0;
        rep_q <= 4'h0;
        if (rx_data_in == `WOFD_SYNC_BYTE) begin
          if ((col_q == 3'h0) && (rep_q == 4'h0) &&
              (ff_cnt_q == `WOFD_SYNC_LEN)) begin
            ff_cnt_q <= ff_cnt_q;  // [R20]
          end else if ((col_q == 3'h0) && (rep_q == 4'h0)) begin
            ff_cnt_q <= ff_cnt_q + 3'h1;  // [R20]
          end else begin
            ff_cnt_q <= 3'h1;
          end
        end else begin
          ff_cnt_q <= 3'h0;
        end
      end
    end
  end

  // Event decisions at end of a good frame
  wire da_mode    = perfect_da_wake_enable_in & suspended;  // [R1]
  wire da_event   = frame_end & da_mode & da_eq_q;  // [R2]
  wire wuf_event  = frame_end & wake_frame_enable_in & (|fhit);  // [R7] [R9]
  wire magic_last = (ff_cnt_q == `WOFD_SYNC_LEN) && (rep_q == `WOFD_MAGIC_REPS) &&
                    (col_q == `WOFD_ADDR_BYTES - 3'h1) &&
                    (rx_data_in == addr_byte(station, col_q));
  wire mp_event   = frame_end & magic_packet_enable_in &  // [R18]
                    (da_eq_q | da_mc_q) &  // [R19] [R21]
                    (magic_hit_q | magic_last);  // [R20]
  wire rs_clear   = resume_in & resume_clears_wake_status_in;  // [R22]

  // Sticky statuses, set wins over clear, events OR in
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      perfect_da_received_out   <= 1'b0;
      wake_frame_received_out   <= 1'b0;
      magic_packet_received_out <= 1'b0;
      remote_wakeup_out         <= 1'b0;
      normal_rx_enable_out      <= 1'b1;
    end else begin
      // Each bit judged separately so one frame may set several
      perfect_da_received_out   <= da_event |  // [R3] [R23]
                                   (perfect_da_received_out &
                                    ~status_clear_in[0] & ~rs_clear);  // [R22]
      wake_frame_received_out   <= wuf_event |  // [R3] [R23]
                                   (wake_frame_received_out &
                                    ~status_clear_in[1] & ~rs_clear);  // [R22]
      magic_packet_received_out <= mp_event |  // [R3] [R23]
                                   (magic_packet_received_out &
                                    ~status_clear_in[2] & ~rs_clear);  // [R22]
      remote_wakeup_out         <= da_event | wuf_event | mp_event;  // [R2] [R7] [R18]
      // Reception held off while any enable remains set
      normal_rx_enable_out      <= ~(perfect_da_wake_enable_in |  // [R4]
                                     wake_frame_enable_in |
                                     magic_packet_enable_in |
                                     other_wake_enables_in);
    end
  end

endmodule // wofd_detector

// >>> dv/wofd_checker_sva.sv
// Port assertions for the wake detector
`timescale 1ns/1ns
module wofd_checker (
  input logic       mclk_in,
  input logic       resetn_in,
  input logic       rx_valid_in,
  input logic       rx_eof_in,
  input logic       rx_frame_ok_in,
  input logic       rx_filter_pass_in,
  input logic       perfect_da_wake_enable_in,
  input logic       wake_frame_enable_in,
  input logic       magic_packet_enable_in,
  input logic       other_wake_enables_in,
  input logic       suspend_state_zero_in,
  input logic       suspend_state_one_in,
  input logic       suspend_state_three_in,
  input logic [2:0] status_clear_in,
  input logic       resume_in,
  input logic       resume_clears_wake_status_in,
  input logic       perfect_da_received_out,
  input logic       wake_frame_received_out,
  input logic       magic_packet_received_out,
  input logic       remote_wakeup_out,
  input logic       normal_rx_enable_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // Good end of frame, any enable, armed perfect-DA, resume clear
  wire eof_ok = rx_valid_in && rx_eof_in && rx_frame_ok_in;
  wire any_en = perfect_da_wake_enable_in || wake_frame_enable_in || magic_packet_enable_in
                || other_wake_enables_in;
  wire da_arm = perfect_da_wake_enable_in
                && (suspend_state_zero_in || suspend_state_one_in || suspend_state_three_in);
  wire rclr   = resume_in && resume_clears_wake_status_in;
  // Wake request is a single-cycle pulse
  sequence s_pulse;
    remote_wakeup_out ##1 !remote_wakeup_out;
  endsequence
  // Any status newly set
  sequence s_new;
    $rose(perfect_da_received_out) || $rose(wake_frame_received_out)
    || $rose(magic_packet_received_out);
  endsequence
  AST_WAKE_PULSE: assert property (remote_wakeup_out |=> !remote_wakeup_out)
    else $error("wake request longer than one cycle");
  AST_SET_WAKES: assert property (s_new |-> s_pulse)
    else $error("status set without wake pulse");
  AST_DA_CAUSE: assert property ($rose(perfect_da_received_out) |->
    ($past(eof_ok && da_arm) || $past(eof_ok && da_arm, 2)))
    else $error("perfect DA status without armed frame end");
  AST_WF_CAUSE: assert property ($rose(wake_frame_received_out) |->
    ($past(eof_ok && rx_filter_pass_in) || $past(eof_ok && rx_filter_pass_in, 2)))
    else $error("wake frame status without passing frame");
  AST_MP_CAUSE: assert property ($rose(magic_packet_received_out) |->
    ($past(eof_ok && magic_packet_enable_in)
     || $past(eof_ok && magic_packet_enable_in, 2)))
    else $error("magic status without enabled frame end");
  AST_STICKY_DA: assert property (perfect_da_received_out && !status_clear_in[0] && !rclr
    |=> perfect_da_received_out)
    else $error("perfect DA status dropped");
  AST_STICKY_MP: assert property (magic_packet_received_out && !status_clear_in[2] && !rclr
    |=> magic_packet_received_out)
    else $error("magic status dropped");
  AST_STICKY_WF: assert property (wake_frame_received_out && !status_clear_in[1] && !rclr
    |=> wake_frame_received_out)
    else $error("wake frame status dropped");
  AST_RESUME_CLR: assert property (rclr && !rx_valid_in && !$past(rx_valid_in) |=>
    !(perfect_da_received_out || wake_frame_received_out || magic_packet_received_out))
    else $error("resume did not clear statuses");
  AST_NRX_OFF: assert property (any_en ##1 any_en |-> !normal_rx_enable_out)
    else $error("normal reception on while enabled");
  AST_NRX_ON: assert property (!any_en ##1 !any_en |-> normal_rx_enable_out)
    else $error("normal reception off with no enable");
endmodule // wofd_checker

bind wofd_detector wofd_checker chk_i (.mclk_in, .resetn_in, .rx_valid_in, .rx_eof_in,
  .rx_frame_ok_in, .rx_filter_pass_in, .perfect_da_wake_enable_in, .wake_frame_enable_in,
  .magic_packet_enable_in, .other_wake_enables_in, .suspend_state_zero_in,
  .suspend_state_one_in, .suspend_state_three_in, .status_clear_in, .resume_in,
  .resume_clears_wake_status_in, .perfect_da_received_out, .wake_frame_received_out,
  .magic_packet_received_out, .remote_wakeup_out, .normal_rx_enable_out);

// >>> dv/wofd_phy_model.sv
// Receive byte source standing in for the PHY and MAC receive path
`timescale 1ns/1ns
module wofd_phy_model (
  input  wire       mclk_in,            // Receive clock
  output reg        rx_valid_out,       // Byte strobe
  output reg  [7:0] rx_data_out,        // Received byte
  output reg        rx_sof_out,         // First byte marker
  output reg        rx_eof_out,         // Last byte marker
  output reg        rx_frame_ok_out,    // Frame good, with last byte
  output reg        rx_filter_pass_out  // Regular filter passed, with last byte
);
  reg [7:0] mem [0:199];  // Frame bytes loaded by the bench
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    rx_sof_out = 1'b0;
    rx_eof_out = 1'b0;
    rx_frame_ok_out = 1'b0;
    rx_filter_pass_out = 1'b0;
  end
  // Bytes back to back; released lines show the inverse so stale values never match
  task send(input int len, input bit ok, input bit pass);
    for (int i = 0; i < len; i++) begin
      @(negedge mclk_in);
      rx_valid_out = 1'b1;
      rx_data_out = mem[i];
      rx_sof_out = (i == 0);
      rx_eof_out = (i == len - 1);
      rx_frame_ok_out = (i == len - 1) ? ok : !ok;
      rx_filter_pass_out = (i == len - 1) ? pass : !pass;
    end
    @(negedge mclk_in);
    rx_valid_out = 1'b0;
    rx_data_out = ~rx_data_out;
    rx_eof_out = 1'b0;
    rx_frame_ok_out = !ok;
    rx_filter_pass_out = !pass;
  endtask
endmodule // wofd_phy_model

// >>> dv/wake_on_lan_frame_detector_test.sv
// Self-checking bench for the wake detector
`timescale 1ns/1ns
module wake_on_lan_frame_detector_test;
  localparam [47:0]  STA  = 48'h55_44_33_22_11_02;  // Station, byte0 in bits 7:0
  localparam [47:0]  MC   = 48'h01_00_00_5e_00_01;  // Multicast address
  localparam [47:0]  UNI  = 48'h01_00_00_00_00_00;  // Other unicast, differs from station in every byte
  localparam [127:0] MASK = 128'h8000_0000_0000_0100_0000_0001_0000_0021;
  localparam [7:0]   OFS  = 8'h0c;                  // Pattern offset
  reg mclk_in = 1'b0, resetn_in = 1'b0, resume_in = 1'b0, ropt = 1'b0, filt_wr_in = 1'b0;
  reg [3:0] en = 4'h0;           // {other, magic, frame, da}
  reg [2:0] sus = 3'h0, sclr = 3'h0, filt_sel_in = 3'h0;
  reg [4:0] filt_index_in = 5'h0;
  reg [31:0] filt_wdata_in = 32'h0;
  int n_fail = 0, n_compared = 0, n_wake = 0, cyc = 0;
  wire rv, rs, re, rok, rpass, pda, wf, mp, wake, nrx;
  wire [7:0] rd;
  wire [2:0] stat = {mp, wf, pda};
  wofd_phy_model phy (.mclk_in(mclk_in), .rx_valid_out(rv), .rx_data_out(rd),
    .rx_sof_out(rs), .rx_eof_out(re), .rx_frame_ok_out(rok), .rx_filter_pass_out(rpass));
  wofd_detector uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .rx_valid_in(rv),
    .rx_data_in(rd), .rx_sof_in(rs), .rx_eof_in(re), .rx_frame_ok_in(rok),
    .rx_filter_pass_in(rpass), .perfect_da_wake_enable_in(en[0]),
    .wake_frame_enable_in(en[1]), .magic_packet_enable_in(en[2]),
    .other_wake_enables_in(en[3]), .suspend_state_zero_in(sus[0]),
    .suspend_state_one_in(sus[1]), .suspend_state_three_in(sus[2]),
    .station_addr_high_in(STA[47:32]), .station_addr_low_in(STA[31:0]),
    .filt_wr_in(filt_wr_in), .filt_index_in(filt_index_in), .filt_sel_in(filt_sel_in),
    .filt_wdata_in(filt_wdata_in), .status_clear_in(sclr), .resume_in(resume_in),
    .resume_clears_wake_status_in(ropt), .perfect_da_received_out(pda),
    .wake_frame_received_out(wf), .magic_packet_received_out(mp),
    .remote_wakeup_out(wake), .normal_rx_enable_out(nrx));
  // 125 MHz clock, wake pulse counter and hang guard
  initial forever #4 mclk_in = ~mclk_in;
  always @(negedge mclk_in) if (wake === 1'b1) n_wake++;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
  task tick; @(negedge mclk_in); endtask
  task chk(input [3:0] got, input [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bench model of the CRC-16 step
  function [15:0] upd(input [15:0] c, input [7:0] d);
    reg [7:0] f;
    f[0] = c[15] ^ d[0];
    for (int i = 1; i < 8; i++) f[i] = c[15-i] ^ f[i-1] ^ d[i];
    upd = {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1], f[0] ^ f[2], f[1] ^ f[3],
           f[2] ^ f[4], f[3] ^ f[5], f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};
  endfunction
  task frame(input [47:0] da);
    for (int i = 0; i < 200; i++) phy.mem[i] = (i < 6) ? da[8*i +: 8] : i[7:0];
  endtask
  task magic(input int p, input int reps);
    for (int i = 0; i < 6 + 6 * reps; i++)
      phy.mem[p + i] = (i < 6) ? 8'hff : STA[8 * (i % 6) +: 8];
  endtask
  task wr(input [4:0] i, input [2:0] s, input [31:0] d);
    filt_wr_in = 1'b1;
    filt_index_in = i;
    filt_sel_in = s;
    filt_wdata_in = d;
    tick;
  endtask
  // Config for filter 31 from the current frame, optionally with a wrong CRC
  task prog(input [1:0] ty, input bit bad);
    reg [15:0] c;
    c = 16'hffff;
    for (int j = 0; j < 128; j++) if (MASK[j]) c = upd(c, phy.mem[OFS + j]);
    wr(5'h1f, 3'h0, {1'b1, 5'h0, ty, OFS, c ^ {15'h0, bad}});
    filt_wr_in = 1'b0;
  endtask
  task run(input int len, input bit ok, input bit pass, input [3:0] exp);
    n_wake = 0;
    phy.send(len, ok, pass);
    repeat (3) tick;
    chk({n_wake == 1, stat}, exp);
  endtask
  task clr;
    sclr = 3'h7;
    tick;
    sclr = 3'h0;
    tick;
  endtask
  task t_nrx;
    for (int k = 0; k < 4; k++) begin
      en = 4'h1 << k;
      repeat (2) tick;
      chk({3'h0, nrx}, 4'h0);
    end
    en = 4'h0;
    repeat (2) tick;
    chk({3'h0, nrx}, 4'h1);
    $display("normal reception test done");
  endtask
  task t_pda;
    en = 4'h1;
    frame(STA);
    for (int s = 0; s < 3; s++) begin
      sus = 3'h1 << s;
      run(64, 1, 1, 4'h9);
      clr;
    end
    sus = 3'h0;
    run(64, 1, 1, 4'h0);
    sus = 3'h4;
    run(64, 0, 1, 4'h0);
    frame(UNI);
    run(64, 1, 1, 4'h0);
    en = 4'h0;
    $display("perfect DA test done");
  endtask
  task wcase(input [1:0] ty, input [47:0] da, input bit pass, input bit bad, input bit e);
    frame(da);
    prog(ty, bad);
    run(150, 1, pass, {e, 1'b0, e, 1'b0});
    clr;
  endtask
  task t_wuf;
    en = 4'h2;
    for (int w = 0; w < 4; w++) wr(5'h1f, 3'h1 + w[2:0], MASK[32*w +: 32]);
    wr(5'h1f, 3'h5, 32'h0);
    filt_wr_in = 1'b0;
    wcase(2'h1, STA, 1, 0, 1);
    wcase(2'h1, STA, 0, 0, 0);
    wcase(2'h1, STA, 1, 1, 0);
    wcase(2'h2, MC, 1, 0, 1);
    wcase(2'h2, STA, 1, 0, 0);
    wcase(2'h0, STA, 1, 0, 1);
    wcase(2'h0, MC, 1, 0, 0);
    wcase(2'h3, MC, 1, 0, 1);
    $display("wake frame test done");
  endtask
  task t_magic;
    en = 4'h4;
    frame(STA);
    magic(20, 16);
    run(150, 1, 1, 4'hc);
    clr;
    frame(MC);
    magic(40, 16);
    run(150, 1, 1, 4'hc);
    clr;
    frame(STA);
    magic(20, 15);
    run(150, 1, 1, 4'h0);
    frame(UNI);
    magic(20, 16);
    run(150, 1, 1, 4'h0);
    $display("magic packet test done");
  endtask
  task t_multi;
    en = 4'h7;
    sus = 3'h2;
    frame(STA);
    magic(20, 16);
    prog(2'h1, 0);
    run(150, 1, 1, 4'hf);
    clr;
    en = 4'h4;
    run(150, 1, 1, 4'hc);
    en = 4'h1;
    frame(STA);
    run(64, 1, 1, 4'hd);
    resume_in = 1'b1;
    tick;
    resume_in = 1'b0;
    tick;
    chk({1'b0, stat}, 4'h5);
    ropt = 1'b1;
    resume_in = 1'b1;
    tick;
    resume_in = 1'b0;
    tick;
    chk({1'b0, stat}, 4'h0);
    en = 4'h0;
    $display("combined status test done");
  endtask
  task test_done;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) tick;
    resetn_in = 1'b1;
    tick;
    chk({nrx, stat}, 4'h8);
    t_nrx;
    t_pda;
    t_wuf;
    t_magic;
    t_multi;
    test_done;
  end
endmodule // wake_on_lan_frame_detector_test
